/* File: psr_pkg.sv */
// Purpose: constants and types for the peripheral soft reset control block
// Assumes: 32-bit APB register bus, 10 MHz system clock
// Notes: capability mask comes from the capability register outside this block
package psr_pkg;

   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [11:0] PSR_OFF_SOFT_RESET_TWO = 12'h048;
   localparam logic [11:0] PSR_OFF_STATUS = 12'h04C;
   localparam logic [31:0] PSR_SOFT_RESET_TWO_RST = 32'h00000000;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int PSR_BIT_PHY = 30;
   localparam int PSR_BIT_MAC = 28;
   localparam int PSR_BIT_PORT_LO = 0;
   localparam int PSR_NUM_PORTS = 7;
   localparam logic [31:0] PSR_WRITABLE = 32'h5000007F;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } psr_apb_req_t;

   typedef struct packed {
      logic ethernet_phy_reset_ctl;
      logic ethernet_mac_reset_ctl;
      logic [PSR_NUM_PORTS-1:0] port_reset_ctl;
   } psr_resets_t;

   typedef enum logic [1:0] {
      PSR_ST_IDLE = 2'b01,
      PSR_ST_DONE = 2'b10
   } psr_state_t;

endpackage

/* File: psr_reset_drive.sv */
// Purpose: registers the per-unit reset lines from the control word
// Assumes: one system clock, clock enable freezes state
// Notes: outputs come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module psr_reset_drive
   import psr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [31:0] ctl_word,
   output var psr_resets_t resets
);

   psr_resets_t resets_reg;
   psr_resets_t resets_next;

   // unit held in reset while its bit is set, released when cleared
   always_comb begin
      resets_next = resets_reg;
      if (clk_en) begin
         resets_next.ethernet_phy_reset_ctl = ctl_word[PSR_BIT_PHY]; // (R8)
         resets_next.ethernet_mac_reset_ctl = ctl_word[PSR_BIT_MAC]; // (R8)
         resets_next.port_reset_ctl =
            ctl_word[PSR_BIT_PORT_LO +: PSR_NUM_PORTS]; // (R8)
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resets_reg <= '0;
      end else begin
         resets_reg <= resets_next;
      end
   end

   assign resets = resets_reg;

endmodule // psr_reset_drive
`default_nettype wire

/* File: psr_soft_reset_two.sv */
// Contract
// (R1) writes land only on bits enabled by the capability mask.
// (R2) bit 30 is the ethernet PHY unit reset control.
// (R3) bit 28 is the ethernet MAC unit reset control.
// (R4) bits 6..0 control port A through port G resets.
// (R5) bits 31, 29 and 27..7 read zero and ignore writes.
// (R6) software preserves reserved bits on read-modify-write.
// (R7) register at offset 0x048, clears to zero on system reset.
// (R8) unit held in reset while its bit set, released when cleared.
//
// Purpose: software reset control register two, APB slave
// Assumes: APB master, capability mask input from system control
// Notes: one wait state per transfer; unmapped offsets read zero, pslverr high
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module psr_soft_reset_two
   import psr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] capability_mask_four,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic ethernet_phy_reset_ctl,
   output logic ethernet_mac_reset_ctl,
   output logic [PSR_NUM_PORTS-1:0] port_reset_ctl
);

   // -------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------
   function automatic logic psr_hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction

   psr_apb_req_t req;
   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};

   // -------------------------------------------------------------
   // bus state
   // -------------------------------------------------------------
   psr_state_t state_reg, state_next;
   logic [31:0] ctl_reg, ctl_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] strb_mask;
   logic [31:0] wr_mask;
   logic [31:0] status_word;

   psr_resets_t resets;

   // byte lanes expanded to a bit mask
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign strb_mask[g*8 +: 8] = {8{pstrb[g]}};
      end
   endgenerate

   // only implemented and documented writable bits take the write
   assign wr_mask = strb_mask & capability_mask_four & PSR_WRITABLE; // (R1) (R5)

   // live reset lines, read back as the block's own state
   assign status_word = {1'b0, resets.ethernet_phy_reset_ctl, 1'b0,
                         resets.ethernet_mac_reset_ctl, 21'h000000,
                         resets.port_reset_ctl};

   always_comb begin
      state_next = state_reg;
      ctl_next = ctl_reg;
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      if (clk_en) begin
         case (state_reg)
            PSR_ST_IDLE: begin
               // answer one cycle into the access phase
               if (req.psel && req.penable) begin
                  pready_next = 1'b1;
                  state_next = PSR_ST_DONE;
                  prdata_next = 32'h00000000;
                  if (psr_hit(req.paddr, PSR_OFF_SOFT_RESET_TWO)) begin // (R7)
                     if (!req.pwrite) begin
                        prdata_next = ctl_reg & PSR_WRITABLE; // (R5)
                     end
                  end else if (psr_hit(req.paddr, PSR_OFF_STATUS)) begin
                     prdata_next = req.pwrite ? 32'h00000000 : status_word;
                     pslverr_next = req.pwrite;
                  end else begin
                     pslverr_next = 1'b1;
                  end
               end
            end
            PSR_ST_DONE: begin
               // pready pulse seen by master this cycle
               // write lands on that same edge, never before the master completes
               if (req.psel && req.penable && req.pwrite &&
                   psr_hit(req.paddr, PSR_OFF_SOFT_RESET_TWO)) begin // (R7)
                  ctl_next = (ctl_reg & ~wr_mask) | (req.pwdata & wr_mask); // (R1)
               end
               state_next = PSR_ST_IDLE;
            end
            default: begin
               state_next = PSR_ST_IDLE;
            end
         endcase
      end else begin
         pready_next = pready_reg;
         pslverr_next = pslverr_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PSR_ST_IDLE;
         ctl_reg <= PSR_SOFT_RESET_TWO_RST; // (R7)
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ctl_reg <= ctl_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // -------------------------------------------------------------
   // reset outputs
   // -------------------------------------------------------------
   psr_reset_drive u_drive (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .ctl_word(ctl_reg),
      .resets(resets)
   );

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign ethernet_phy_reset_ctl = resets.ethernet_phy_reset_ctl; // (R2)
   assign ethernet_mac_reset_ctl = resets.ethernet_mac_reset_ctl; // (R3)
   assign port_reset_ctl = resets.port_reset_ctl; // (R4)

endmodule // psr_soft_reset_two
`default_nettype wire

/* File: psr_soft_reset_two_properties.sv */
// Purpose: port-level checks for soft reset register two
// Assumes: one clock domain, clock enable held high around writes
// Notes: reset outputs may follow a write by up to three cycles
`timescale 1ns/1ps
`default_nettype none
module psr_soft_reset_two_chk
   import psr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] capability_mask_four,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ethernet_phy_reset_ctl,
   input wire logic ethernet_mac_reset_ctl,
   input wire logic [PSR_NUM_PORTS-1:0] port_reset_ctl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic acc = psel && penable && pready && paddr == PSR_OFF_SOFT_RESET_TWO;
   wire logic wr = acc && pwrite;
   wire logic [31:0] cm = capability_mask_four;
   // a lane with its strobe low leaves its bits alone
   wire logic hi_lane = wr && pstrb[3];
   wire logic lo_lane = wr && pstrb[0];
   property p_mask;
      wr && !cm[30] && !ethernet_phy_reset_ctl |=> !ethernet_phy_reset_ctl [*3];
   endproperty
   a_mask: assert property (p_mask) else $error("masked bit changed");
   property p_phy;
      hi_lane && cm[30] && pwdata[30] |-> ##[1:3] ethernet_phy_reset_ctl;
   endproperty
   a_phy: assert property (p_phy) else $error("phy reset not set");
   property p_mac;
      hi_lane && cm[28] && pwdata[28] |-> ##[1:3] ethernet_mac_reset_ctl;
   endproperty
   a_mac: assert property (p_mac) else $error("mac reset not set");
   property p_port;
      lo_lane && cm[6] && pwdata[6] |-> ##[1:3] port_reset_ctl[6];
   endproperty
   a_port: assert property (p_port) else $error("port g reset not set");
   property p_rsvd;
      acc && !pwrite |-> !pslverr && (prdata & 32'hAFFFFF80) == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
   property p_rst;
      $rose(rst_n) |-> {ethernet_phy_reset_ctl, ethernet_mac_reset_ctl} == 2'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
   property p_rel;
      hi_lane && cm[28] && !pwdata[28] |-> ##[1:3] !ethernet_mac_reset_ctl;
   endproperty
   a_rel: assert property (p_rel) else $error("mac reset not released");
endmodule // psr_soft_reset_two_chk
bind psr_soft_reset_two psr_soft_reset_two_chk u_chk (
   .clk(clk),
   .rst_n(rst_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .capability_mask_four(capability_mask_four),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .ethernet_phy_reset_ctl(ethernet_phy_reset_ctl),
   .ethernet_mac_reset_ctl(ethernet_mac_reset_ctl),
   .port_reset_ctl(port_reset_ctl)
);
`default_nettype wire

/* File: test_psr_soft_reset_two.sv */
// Purpose: self-checking bench for soft reset register two
// Assumes: APB master on one 10 MHz clock
// Notes: outputs judged three cycles after the read-back that follows each wr_rd write
`timescale 1ns/1ps
`default_nettype none
module test_psr_soft_reset_two;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, cap = 32'h0, prdata, rd;
   logic pready, pslverr, phy, mac, err;
   logic [6:0] port;
   int n_fail = 0, checks_done = 0;
   logic en = 1'b1;
   logic [3:0] strb = 4'hF;
   psr_soft_reset_two uut (.clk(clk), .rst_n(rst_n), .clk_en(en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
      .capability_mask_four(cap), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ethernet_phy_reset_ctl(phy), .ethernet_mac_reset_ctl(mac), .port_reset_ctl(port));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // mask, write, read back, then let the reset lines settle
   task automatic wr_rd(input logic [31:0] c, input logic [31:0] d, input logic [31:0] e);
      cap <= c;
      apb(1'b1, 12'h048, d);
      apb(1'b0, 12'h048, 32'h0);
      chk("reg", e, rd);
      chk("rd_err", 32'h0, {31'h0, err});
      repeat (3) @(posedge clk);
   endtask
   task automatic outs(input logic [8:0] e);
      chk("outs", {23'h0, e}, {23'h0, phy, mac, port});
   endtask
   task automatic t_reset();
      outs(9'h000);
      apb(1'b0, 12'h048, 32'h0);
      chk("rst_val", 32'h0, rd);
   endtask
   task automatic t_mask();
      wr_rd(32'h0, 32'hFFFFFFFF, 32'h0);
      outs(9'h000);
   endtask
   task automatic t_set();
      wr_rd(32'hFFFFFFFF, 32'hFFFFFFFF, 32'h5000007F);
      outs(9'h1FF);
      wr_rd(32'h40000001, 32'h0, 32'h1000007E);
      outs(9'h0FE);
   endtask
   task automatic t_ports();
      for (int i = 0; i < 7; i++) begin
         wr_rd(32'hFFFFFFFF, 32'h1 << i, 32'h1 << i);
         outs(9'h1 << i);
      end
   endtask
   // read-modify-write keeps what it read, reserved bits included; status mirrors lines
   task automatic t_rmw();
      apb(1'b0, 12'h048, 32'h0);
      chk("rmw_rd", 32'h00000040, rd);
      apb(1'b1, 12'h048, rd | 32'h10000000);
      apb(1'b0, 12'h048, 32'h0);
      chk("rmw", 32'h10000040, rd);
      outs(9'h0C0);
      apb(1'b0, 12'h04C, 32'h0);
      chk("status", 32'h10000040, rd);
      chk("st_err", 32'h0, {31'h0, err});
      apb(1'b1, 12'h04C, 32'hFFFFFFFF);
      chk("st_wr_err", 32'h1, {31'h0, err});
   endtask
   // byte lanes gate the write, one lane at a time
   task automatic t_lanes();
      wr_rd(32'hFFFFFFFF, 32'h0, 32'h0);
      strb <= 4'h1;
      wr_rd(32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000007F);
      strb <= 4'h8;
      wr_rd(32'hFFFFFFFF, 32'hFFFFFFFF, 32'h5000007F);
      strb <= 4'hF;
      outs(9'h1FF);
   endtask
   // reset in mid-run clears the register and every reset line
   task automatic t_rerst();
      wr_rd(32'hFFFFFFFF, 32'h50000001, 32'h50000001);
      outs(9'h181);
      rst_n <= 1'b0;
      @(posedge clk);
      outs(9'h000);
      rst_n <= 1'b1;
      apb(1'b0, 12'h048, 32'h0);
      chk("rerst_val", 32'h0, rd);
   endtask
   // clock enable low: no answer and no output change until it returns
   task automatic t_freeze();
      en <= 1'b0;
      fork
         apb(1'b1, 12'h048, 32'h40000000);
         begin
            repeat (6) @(posedge clk);
            chk("frz_rdy", 32'h0, {31'h0, pready});
            outs(9'h000);
            en <= 1'b1;
         end
      join
      repeat (3) @(posedge clk);
      outs(9'h100);
   endtask
   task automatic t_unmapped();
      apb(1'b0, 12'h050, 32'h0);
      chk("err", 32'h1, {31'h0, err});
      chk("rdata", 32'h0, rd);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_mask();
      t_set();
      t_ports();
      t_rmw();
      t_lanes();
      t_rerst();
      t_freeze();
      t_unmapped();
      summarize();
   end
endmodule // test_psr_soft_reset_two
`default_nettype wire
